//--- rtl/bcr_pkg.sv
// package with register map, field positions and packed carriers for the config bank
package bcr_pkg;
  localparam logic [7:0] PROT_SRC_ADDR = 8'ha2;
  localparam logic [7:0] BRIGHT_TRANS_ADDR = 8'ha3;
  localparam logic [7:0] BRIGHTNESS_ADDR = 8'h01;
  localparam logic [7:0] PROT_SRC_RESET = 8'h00;
  localparam logic [7:0] BRIGHT_TRANS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
  localparam int DIM_PIN_BIT = 0;
  localparam int BOOST_PIN_BIT = 1;
  localparam int ISET_PIN_BIT = 2;
  localparam int BACKLIGHT_ON_BIT_BIT = 3;
  localparam int LOCKOUT_THRESHOLD_SELECT_BIT = 4;
  localparam int LOCKOUT_PROTECT_ENABLE_BIT = 5;
  localparam int HYST_LSB = 0;
  localparam int FILTER_LSB = 2;
  localparam int SLOPE_LSB = 4;

  typedef struct packed {
    logic [1:0] stored_boost_rate_bits;
    logic [1:0] stored_dimming_rate_bits;
    logic [1:0] pin_boost_rate;
    logic [1:0] pin_dimming_rate;
  } bcr_rate_src_type;

  typedef struct packed {
    logic [1:0] boost_rate;
    logic [1:0] dimming_rate;
    logic current_from_resistor;
    logic lockout_protect_enable;
    logic lockout_threshold_select;
    logic backlight_enable;
    logic [2:0] slope;
    logic [1:0] filter;
    logic [1:0] hysteresis;
  } bcr_ctrl_type;
endpackage : bcr_pkg

//--- rtl/bcr_sync.sv
// two-flop synchroniser for pin-derived levels
module bcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (clk_en_i) begin
      meta_d = async_i;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : bcr_sync

//--- rtl/bcr_config_regs.sv
// configuration register bank: protection/source and brightness transition registers

module bcr_config_regs import bcr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] stored_boost_rate_bits_i,
  input wire logic [1:0] stored_dimming_rate_bits_i,
  input wire logic [1:0] frequency_select_pin_boost_i,
  input wire logic [1:0] frequency_select_pin_dimming_i,
  output logic [7:0] rdata_o,
  output logic [7:0] prot_src_o,
  output logic [7:0] bright_trans_o,
  output bcr_ctrl_type ctrl_o
);
  logic [7:0] prot_q;
  logic [7:0] prot_d;
  logic [7:0] trans_q;
  logic [7:0] trans_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic bright_seen_q;
  logic bright_seen_d;
  bcr_ctrl_type ctrl_q;
  bcr_ctrl_type ctrl_d;
  logic [3:0] pin_sync;
  bcr_rate_src_type src;

  //////////////////////////////////////////////////////////////////////////
  // pin-derived rate selections cross in through two flops
  bcr_sync #(.WIDTH(4)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i({frequency_select_pin_boost_i, frequency_select_pin_dimming_i}),
    .sync_o(pin_sync)
  );

  always_comb begin
    src.stored_boost_rate_bits = stored_boost_rate_bits_i;
    src.stored_dimming_rate_bits = stored_dimming_rate_bits_i;
    src.pin_boost_rate = pin_sync[3:2];
    src.pin_dimming_rate = pin_sync[1:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes and reads
  always_comb begin
    prot_d = prot_q;
    trans_d = trans_q;
    rdata_d = rdata_q;
    bright_seen_d = bright_seen_q;
    if (wr_en_i) begin
      case (addr_i)
        PROT_SRC_ADDR: prot_d = wdata_i;
        BRIGHT_TRANS_ADDR: trans_d = wdata_i;
        BRIGHTNESS_ADDR: bright_seen_d = 1'b1;
        default: ;
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        PROT_SRC_ADDR: rdata_d = prot_q;
        BRIGHT_TRANS_ADDR: rdata_d = trans_q;
        default: rdata_d = READ_IDLE_VALUE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded controls
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d.backlight_enable = prot_q[BACKLIGHT_ON_BIT_BIT] | bright_seen_q;
    ctrl_d.boost_rate = prot_q[BOOST_PIN_BIT] ? src.pin_boost_rate
                                              : src.stored_boost_rate_bits;
    ctrl_d.dimming_rate = prot_q[DIM_PIN_BIT] ? src.pin_dimming_rate
                                              : src.stored_dimming_rate_bits;
    ctrl_d.current_from_resistor = prot_q[ISET_PIN_BIT];
    ctrl_d.lockout_protect_enable = prot_q[LOCKOUT_PROTECT_ENABLE_BIT];
    ctrl_d.lockout_threshold_select = prot_q[LOCKOUT_THRESHOLD_SELECT_BIT];
    ctrl_d.slope = trans_q[SLOPE_LSB +: 3];
    ctrl_d.filter = trans_q[FILTER_LSB +: 2];
    ctrl_d.hysteresis = trans_q[HYST_LSB +: 2];
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prot_q <= PROT_SRC_RESET;
      trans_q <= BRIGHT_TRANS_RESET;
      rdata_q <= READ_IDLE_VALUE;
      bright_seen_q <= 1'b0;
      ctrl_q <= '0;
    end else if (clk_en_i) begin
      prot_q <= prot_d;
      trans_q <= trans_d;
      rdata_q <= rdata_d;
      bright_seen_q <= bright_seen_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign rdata_o = rdata_q;
  assign prot_src_o = prot_q;
  assign bright_trans_o = trans_q;
  assign ctrl_o = ctrl_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_backlight_on_bit_direct;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && prot_q[BACKLIGHT_ON_BIT_BIT] |=> ctrl_q.backlight_enable;
  endproperty
  a_backlight_on_bit_direct: assert property (p_backlight_on_bit_direct) else $error("backlight not enabled");

  property p_bl_off_waits;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && !prot_q[BACKLIGHT_ON_BIT_BIT] && !bright_seen_q |=> !ctrl_q.backlight_enable;
  endproperty
  a_bl_off_waits: assert property (p_bl_off_waits) else $error("backlight on early");

  property p_bright_write;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr_en_i && addr_i == BRIGHTNESS_ADDR ##1 clk_en_i [*2]
      |-> ctrl_q.backlight_enable;
  endproperty
  a_bright_write: assert property (p_bright_write) else $error("brightness write ignored");

  property p_boost_pin;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && prot_q[BOOST_PIN_BIT] |=> ctrl_q.boost_rate == $past(src.pin_boost_rate);
  endproperty
  a_boost_pin: assert property (p_boost_pin) else $error("boost pin rate wrong");

  property p_boost_stored;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && !prot_q[BOOST_PIN_BIT]
      |=> ctrl_q.boost_rate == $past(stored_boost_rate_bits_i);
  endproperty
  a_boost_stored: assert property (p_boost_stored) else $error("boost stored rate wrong");

  property p_dim_pin;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && prot_q[DIM_PIN_BIT] |=> ctrl_q.dimming_rate == $past(src.pin_dimming_rate);
  endproperty
  a_dim_pin: assert property (p_dim_pin) else $error("dimming pin rate wrong");

  property p_dim_stored;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && !prot_q[DIM_PIN_BIT]
      |=> ctrl_q.dimming_rate == $past(stored_dimming_rate_bits_i);
  endproperty
  a_dim_stored: assert property (p_dim_stored) else $error("dimming stored rate wrong");

  property p_lockout;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr_en_i && addr_i == PROT_SRC_ADDR ##1 clk_en_i
      |=> ctrl_q.lockout_protect_enable == $past(wdata_i[LOCKOUT_PROTECT_ENABLE_BIT], 2)
      && ctrl_q.lockout_threshold_select == $past(wdata_i[LOCKOUT_THRESHOLD_SELECT_BIT], 2);
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout controls wrong");

  property p_readback;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && rd_en_i && addr_i == BRIGHT_TRANS_ADDR |=> rdata_q == $past(trans_q);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");

  property p_write_lands;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && wr_en_i && addr_i == PROT_SRC_ADDR
      |=> prot_q == $past(wdata_i);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("register write lost");

  property p_unmapped_read;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i && rd_en_i && addr_i != PROT_SRC_ADDR && addr_i != BRIGHT_TRANS_ADDR
      |=> rdata_q == READ_IDLE_VALUE;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not idle");

  property p_current_src;
    @(posedge ref_clk_i) disable iff (reset_i)
      clk_en_i |=> ctrl_q.current_from_resistor == $past(prot_q[ISET_PIN_BIT]);
  endproperty
  a_current_src: assert property (p_current_src) else $error("current source wrong");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (reset_i)
      !clk_en_i |=> $stable(prot_q) && $stable(trans_q) && $stable(rdata_q)
      && $stable(ctrl_q) && $stable(bright_seen_q) && $stable(pin_sync);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  c_backlight_on_bit: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && wr_en_i && addr_i == PROT_SRC_ADDR && wdata_i[BACKLIGHT_ON_BIT_BIT]);
  c_bright: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    clk_en_i && wr_en_i && addr_i == BRIGHTNESS_ADDR);
  c_pin_rates: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    prot_q[BOOST_PIN_BIT] && prot_q[DIM_PIN_BIT]);
  c_freeze: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    !clk_en_i && wr_en_i);
  c_pin_change: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    prot_q[BOOST_PIN_BIT] && ctrl_q.boost_rate != $past(ctrl_q.boost_rate));
endmodule : bcr_config_regs

//--- testbench/bcr_host_model.sv
// host model issuing one-cycle register strobes at the falling edge
module bcr_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // released address and data show the inverse, not the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge ref_clk_i);
    rd_en_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd
  task automatic pwm_only_setup();
    wr(8'ha2, 8'h08);
  endtask : pwm_only_setup
  task automatic set_brightness();
    wr(8'h01, 8'h80);
  endtask : set_brightness
endmodule : bcr_host_model

//--- testbench/tb_bcr_config_regs.sv
// testbench for the configuration register bank
module tb_bcr_config_regs import bcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en = 1'b1;
  logic wr_en, rd_en;
  logic [7:0] addr, wdata, rdata_o, prot_src_o, bright_trans_o, rv;
  logic [1:0] sb = 2'b11, sd = 2'b00, pb = 2'b01, pd = 2'b10;
  bcr_ctrl_type ctrl_o;
  int n_fail = 0;
  int total_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  bcr_host_model i_bcr_host_model (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  bcr_config_regs i_bcr_config_regs (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
    .stored_boost_rate_bits_i(sb), .stored_dimming_rate_bits_i(sd),
    .frequency_select_pin_boost_i(pb), .frequency_select_pin_dimming_i(pd),
    .rdata_o(rdata_o), .prot_src_o(prot_src_o), .bright_trans_o(bright_trans_o), .ctrl_o(ctrl_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    reset_i = 1'b0;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(400 * 100);
    n_fail++;
    report_and_stop();
  end
  initial begin
    do_reset();
    chk("prot_src", 16'h0000, {8'h00, prot_src_o});
    chk("bright_trans", 16'h0000, {8'h00, bright_trans_o});
    chk("ctrl", 16'h0000, {1'b0, ctrl_o});
    $display("test reset done");
    i_bcr_host_model.wr(PROT_SRC_ADDR, 8'h00);
    @(negedge ref_clk_i);
    chk("backlight", 16'h0000, {15'h0, ctrl_o.backlight_enable});
    i_bcr_host_model.set_brightness();
    @(negedge ref_clk_i);
    chk("backlight", 16'h0001, {15'h0, ctrl_o.backlight_enable});
    $display("test brightness done");
    do_reset();
    i_bcr_host_model.pwm_only_setup();
    @(negedge ref_clk_i);
    chk("backlight", 16'h0001, {15'h0, ctrl_o.backlight_enable});
    chk("prot_src", 16'h0008, {8'h00, prot_src_o});
    i_bcr_host_model.rd(PROT_SRC_ADDR, rv);
    chk("rdata a2", 16'h0008, {8'h00, rv});
    $display("test pwm only done");
    for (int s = 0; s < 4; s++) begin
      i_bcr_host_model.wr(PROT_SRC_ADDR, {6'h00, 2'(s)});
      @(negedge ref_clk_i);
      chk("boost_rate", {14'h0, s[1] ? pb : sb}, {14'h0, ctrl_o.boost_rate});
      chk("dimming_rate", {14'h0, s[0] ? pd : sd}, {14'h0, ctrl_o.dimming_rate});
    end
    $display("test rate source done");
    for (int t = 0; t < 2; t++) begin
      i_bcr_host_model.wr(PROT_SRC_ADDR, {2'b00, 1'b1, t[0], 4'h0});
      @(negedge ref_clk_i);
      chk("lockout", {14'h0, 1'b1, t[0]},
        {14'h0, ctrl_o.lockout_protect_enable, ctrl_o.lockout_threshold_select});
    end
    $display("test lockout done");
    i_bcr_host_model.wr(PROT_SRC_ADDR, 8'h07);
    @(negedge ref_clk_i);
    chk("prot_src", 16'h0007, {8'h00, prot_src_o});
    chk("current_src", 16'h0001, {15'h0, ctrl_o.current_from_resistor});
    pb = 2'b10;
    pd = 2'b01;
    repeat (2) @(negedge ref_clk_i);
    chk("boost_rate", 16'h0001, {14'h0, ctrl_o.boost_rate});
    chk("dimming_rate", 16'h0002, {14'h0, ctrl_o.dimming_rate});
    @(negedge ref_clk_i);
    chk("boost_rate", 16'h0002, {14'h0, ctrl_o.boost_rate});
    chk("dimming_rate", 16'h0001, {14'h0, ctrl_o.dimming_rate});
    $display("test pin sync done");
    clk_en = 1'b0;
    i_bcr_host_model.wr(PROT_SRC_ADDR, 8'h00);
    @(negedge ref_clk_i);
    chk("frozen prot_src", 16'h0007, {8'h00, prot_src_o});
    chk("frozen current_src", 16'h0001, {15'h0, ctrl_o.current_from_resistor});
    clk_en = 1'b1;
    $display("test freeze done");
    i_bcr_host_model.wr(BRIGHT_TRANS_ADDR, 8'hff);
    i_bcr_host_model.wr(8'h55, 8'haa);
    i_bcr_host_model.rd(BRIGHT_TRANS_ADDR, rv);
    chk("rdata a3", 16'h00ff, {8'h00, rv});
    chk("bright_trans", 16'h00ff, {8'h00, bright_trans_o});
    chk("transition", 16'h007f, {9'h0, ctrl_o.slope, ctrl_o.filter, ctrl_o.hysteresis});
    i_bcr_host_model.rd(8'h55, rv);
    chk("rdata unmapped", 16'h0000, {8'h00, rv});
    $display("test transition done");
    report_and_stop();
  end
endmodule : tb_bcr_config_regs
